// [hw/nvmpf_params.svh]
// constants of the nvm protection and command front end
`ifndef NVMPF_PARAMS_SVH
`define NVMPF_PARAMS_SVH
`define NVMPF_AW 6
`define NVMPF_OFS_DIV 6'h00
`define NVMPF_OFS_STAT 6'h04
`define NVMPF_OFS_IDX 6'h08
`define NVMPF_OFS_WORD 6'h0c
`define NVMPF_OFS_HI 6'h10
`define NVMPF_OFS_LO 6'h14
`define NVMPF_OFS_FP 6'h18
`define NVMPF_OFS_EE 6'h1c
`define NVMPF_OFS_IEN 6'h20
`define NVMPF_COMMAND_COMPLETE_FLAG 7
`define NVMPF_ACCESS_ERROR_FLAG 5
`define NVMPF_PROTECTION_VIOLATION_FLAG 4
`define NVMPF_CCIE 7
`define NVMPF_ERRIE 6
`define NVMPF_OPEN 7
`define NVMPF_HDIS 5
`define NVMPF_HS 4:3
`define NVMPF_LDIS 2
`define NVMPF_LS 1:0
`define NVMPF_EESZ 2:0
`define NVMPF_DIV 5:0
`define NVMPF_DIV_RESET 6'h00
`define NVMPF_FP_RESET 8'ha4
`define NVMPF_EE_RESET 8'h80
`define NVMPF_IEN_RESET 8'h00
`define NVMPF_OBJ_WORDS 6
`define NVMPF_CMD_TICKS 4
`define NVMPF_SCEN_OK 64'hff5a3c18080c0a0f
`define NVMPF_SCEN_FULL 3'h3
`define NVMPF_FLASH_LOW 17'h08000
`define NVMPF_FLASH_TOP 17'h10000
`define NVMPF_LOW_UNIT 17'h00400
`define NVMPF_HIGH_UNIT 17'h00800
`define NVMPF_EE_BASE 18'h03100
`define NVMPF_EE_UNIT 18'h00020
`define NVMPF_FSEC_MASK 18'h3fe00
`define NVMPF_ESEC_MASK 18'h3fffe
`define NVMPF_LW_MASK 2'h3
`define NVMPF_CMD_PGM_FLASH 8'h06
`define NVMPF_CMD_ERS_FSEC 8'h0a
`define NVMPF_CMD_PGM_EE 8'h11
`define NVMPF_CMD_ERS_ESEC 8'h12
`endif

// [hw/nvmpf_pkg.sv]
// types of the nvm protection and command front end
package nvmpf_pkg;
	typedef enum logic {NVMPF_IDLE, NVMPF_RUN} nvmpf_state_t;
endpackage : nvmpf_pkg

// [hw/nvmpf_top.sv]
// nvm protection and command front end with ahb-lite register slave
// Summary of operation
// RULE1: flash split into low, high, middle regions
// RULE2: flash protection may only grow, never shrink
// RULE3: open=1: protect ranges whose disable is 0
// RULE4: open=0: all protected unless range unprotected
// RULE5: high size 2, 4, 8, 16 KB
// RULE6: low size 1, 2, 4, 8 KB
// RULE7: only listed scenario transitions allowed
// RULE8: eeprom protection open bit, grow only
// RULE9: eeprom protects 32 bytes per step
// RULE10: no command load while one executes
// RULE11: 16-bit command object, bytes, 3-bit index
// RULE12: completion and error raise enabled interrupts
// RULE13: index map: code/addr, addr, data 0-3
// RULE14: software zero-fills unused upper bits
// RULE15: software waits for complete flag first
// RULE16: software sets 1 MHz divider first
// RULE17: write 0x30 clears error flags
// RULE18: write 0x80 clears complete and launches
// RULE19: software loads parameters in ascending order
// RULE20: flash and eeprom command sets
// RULE21: program flash code 0x06, longword aligned
// RULE22: sector 512 bytes flash, 2 eeprom
// RULE23: completion sets flag, protected target violates
// RULE24: refused protection writes keep old value
//
// The implementer's own choices: the AHB-Lite register port and the address map.
`include "nvmpf_params.svh"
module nvmpf_top
	import nvmpf_pkg::*;
	#(parameter int CMD_TICKS = `NVMPF_CMD_TICKS)
(
	input wire logic clk, // bus clock
	input wire logic reset, // async, active high
	input wire logic hsel, // slave select
	input wire logic [31:0] haddr, // byte address
	input wire logic [1:0] htrans, // transfer type
	input wire logic hwrite, // write when high
	input wire logic [2:0] hsize, // transfer size
	input wire logic [31:0] hwdata, // write data
	input wire logic hready, // bus ready
	output logic hreadyout, // slave ready
	output logic hresp, // always okay
	output logic [31:0] hrdata, // read data
	output logic cmdIrq, // command complete request
	output logic errIrq // memory error request
);
	// =========================================================
	// bus slave
	logic take, wrPend_ff, divSet_ff, idxOk, objOpen, fpAccept, eeAccept;
	logic command_complete_flag_ff, access_error_flag_ff, protection_violation_flag_ff, cmdIrq_ff, errIrq_ff;
	logic [`NVMPF_AW-1:0] wrAddr_ff;
	logic [31:0] rdData, hrdata_ff;
	logic wDiv, wStat, wIdx, wWord, wHi, wLo, wFp, wEe, wIen;
	logic [5:0] div_ff;
	logic [2:0] idx_ff;
	logic [15:0] obj_ff [0:`NVMPF_OBJ_WORDS-1];
	logic [15:0] objWord;
	logic [7:0] flash_protection_control_ff, eeprom_protection_control_ff, ien_ff;
	// sampling hsize is unnecessary: every register is one word
	assign take = hsel && htrans[1] && hready;
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			wrPend_ff <= 1'b0;
			wrAddr_ff <= '0;
			hrdata_ff <= 32'h0;
		end
		else
		begin
			wrPend_ff <= take && hwrite;
			if (take)
				wrAddr_ff <= haddr[`NVMPF_AW-1:0];
			if (take && !hwrite)
				hrdata_ff <= rdData;
		end
	end
	assign idxOk = idx_ff < 3'(`NVMPF_OBJ_WORDS); // [RULE11]
	assign objWord = idxOk ? obj_ff[idx_ff] : 16'h0;
	always_comb
	begin
		rdData = 32'h0;
		case (haddr[`NVMPF_AW-1:0])
			`NVMPF_OFS_DIV: rdData[7:0] = {divSet_ff, 1'b0, div_ff};
			`NVMPF_OFS_STAT: rdData[7:0] = {command_complete_flag_ff, 1'b0, access_error_flag_ff, protection_violation_flag_ff, 4'h0};
			`NVMPF_OFS_IDX: rdData[2:0] = idx_ff;
			`NVMPF_OFS_WORD: rdData[15:0] = objWord;
			`NVMPF_OFS_HI: rdData[7:0] = objWord[15:8];
			`NVMPF_OFS_LO: rdData[7:0] = objWord[7:0];
			`NVMPF_OFS_FP: rdData[7:0] = flash_protection_control_ff;
			`NVMPF_OFS_EE: rdData[7:0] = eeprom_protection_control_ff;
			`NVMPF_OFS_IEN: rdData[7:0] = ien_ff;
			default: rdData = 32'h0;
		endcase
	end
	assign wDiv = wrPend_ff && wrAddr_ff == `NVMPF_OFS_DIV;
	assign wStat = wrPend_ff && wrAddr_ff == `NVMPF_OFS_STAT;
	assign wIdx = wrPend_ff && wrAddr_ff == `NVMPF_OFS_IDX;
	assign wWord = wrPend_ff && wrAddr_ff == `NVMPF_OFS_WORD;
	assign wHi = wrPend_ff && wrAddr_ff == `NVMPF_OFS_HI;
	assign wLo = wrPend_ff && wrAddr_ff == `NVMPF_OFS_LO;
	assign wFp = wrPend_ff && wrAddr_ff == `NVMPF_OFS_FP;
	assign wEe = wrPend_ff && wrAddr_ff == `NVMPF_OFS_EE;
	assign wIen = wrPend_ff && wrAddr_ff == `NVMPF_OFS_IEN;

	// =========================================================
	// protection decode
	function automatic logic flashProt(input logic [17:0] a, input logic [7:0] fp);
		logic isFlash, inLow, inHigh, win;
		isFlash = a[17:16] == 2'h0 && {1'b0, a[15:0]} >= `NVMPF_FLASH_LOW; // [RULE1]
		inLow = isFlash && {1'b0, a[15:0]} <
			`NVMPF_FLASH_LOW + (`NVMPF_LOW_UNIT << fp[`NVMPF_LS]); // [RULE6]
		inHigh = isFlash && {1'b0, a[15:0]} >=
			`NVMPF_FLASH_TOP - (`NVMPF_HIGH_UNIT << fp[`NVMPF_HS]); // [RULE5]
		win = (!fp[`NVMPF_HDIS] && inHigh) || (!fp[`NVMPF_LDIS] && inLow);
		if (fp[`NVMPF_OPEN])
			return win; // [RULE3]
		return isFlash && !win; // [RULE4]
	endfunction : flashProt
	function automatic logic eeprom_protection_control(input logic [17:0] a, input logic [7:0] ep);
		logic [17:0] lim;
		lim = `NVMPF_EE_BASE + `NVMPF_EE_UNIT * (18'(ep[`NVMPF_EESZ]) + 18'h1); // [RULE9]
		return !ep[`NVMPF_OPEN] && a >= `NVMPF_EE_BASE && a < lim; // [RULE8]
	endfunction : eeprom_protection_control
	// a size change is judged only when both sides share the open bit;
	// across an open change the scenario table alone decides
	function automatic logic fpOk(input logic [7:0] o, input logic [7:0] n);
		logic [2:0] so, sn;
		logic ok;
		logic [63:0] allowed;
		allowed = `NVMPF_SCEN_OK;
		so = {o[`NVMPF_OPEN], o[`NVMPF_HDIS], o[`NVMPF_LDIS]};
		sn = {n[`NVMPF_OPEN], n[`NVMPF_HDIS], n[`NVMPF_LDIS]};
		ok = allowed[{so, sn}]; // [RULE7]
		if (o[`NVMPF_OPEN] && n[`NVMPF_OPEN])
		begin
			if (!o[`NVMPF_HDIS] && !n[`NVMPF_HDIS] && n[`NVMPF_HS] < o[`NVMPF_HS])
				ok = 1'b0; // [RULE2]
			if (!o[`NVMPF_LDIS] && !n[`NVMPF_LDIS] && n[`NVMPF_LS] < o[`NVMPF_LS])
				ok = 1'b0; // [RULE2]
		end
		if (!o[`NVMPF_OPEN] && !n[`NVMPF_OPEN])
		begin
			if (!o[`NVMPF_HDIS] && !n[`NVMPF_HDIS] && n[`NVMPF_HS] > o[`NVMPF_HS])
				ok = 1'b0; // [RULE2]
			if (!o[`NVMPF_LDIS] && !n[`NVMPF_LDIS] && n[`NVMPF_LS] > o[`NVMPF_LS])
				ok = 1'b0; // [RULE2]
		end
		return ok;
	endfunction : fpOk
	logic [2:0] fpScen;
	assign fpAccept = fpOk(flash_protection_control_ff, hwdata[7:0]);
	assign eeAccept = eeprom_protection_control_ff[`NVMPF_OPEN] || (!hwdata[`NVMPF_OPEN] &&
		hwdata[`NVMPF_EESZ] >= eeprom_protection_control_ff[`NVMPF_EESZ]); // [RULE8]
	assign fpScen = {flash_protection_control_ff[`NVMPF_OPEN], flash_protection_control_ff[`NVMPF_HDIS], flash_protection_control_ff[`NVMPF_LDIS]};
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			flash_protection_control_ff <= `NVMPF_FP_RESET;
			eeprom_protection_control_ff <= `NVMPF_EE_RESET;
		end
		else
		begin
			if (wFp && fpAccept)
				flash_protection_control_ff <= hwdata[7:0]; // [RULE24]
			if (wEe && eeAccept)
				eeprom_protection_control_ff <= {hwdata[`NVMPF_OPEN], 4'h0, hwdata[`NVMPF_EESZ]}; // [RULE24]
		end
	end

	// =========================================================
	// command object
	assign objOpen = command_complete_flag_ff && idxOk; // [RULE10]
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			idx_ff <= 3'h0;
			for (int i = 0; i < `NVMPF_OBJ_WORDS; i++)
				obj_ff[i] <= 16'h0;
		end
		else
		begin
			if (wIdx)
				idx_ff <= hwdata[2:0]; // [RULE11]
			if (objOpen && wWord)
				obj_ff[idx_ff] <= hwdata[15:0]; // [RULE13]
			if (objOpen && wHi)
				obj_ff[idx_ff][15:8] <= hwdata[7:0]; // [RULE11]
			if (objOpen && wLo)
				obj_ff[idx_ff][7:0] <= hwdata[7:0]; // [RULE11]
		end
	end

	// =========================================================
	// launch checks
	logic [7:0] cmdCode;
	logic [17:0] cmdAddr;
	logic launchReq, errAny, badCmd, protHit, startRun, setAcc, setViol;
	assign cmdCode = obj_ff[0][15:8]; // [RULE13]
	assign cmdAddr = {obj_ff[0][1:0], obj_ff[1]}; // [RULE13]
	assign errAny = access_error_flag_ff || protection_violation_flag_ff;
	assign launchReq = wStat && hwdata[`NVMPF_COMMAND_COMPLETE_FLAG] && command_complete_flag_ff; // [RULE18]
	always_comb
	begin
		badCmd = !divSet_ff; // [RULE16]
		protHit = 1'b0;
		// other codes skip the protection check and run as generic commands; only the divider check applies
		case (cmdCode) // [RULE20]
			`NVMPF_CMD_PGM_FLASH:
			begin
				badCmd = badCmd || (cmdAddr[1:0] & `NVMPF_LW_MASK) != 2'h0; // [RULE21]
				protHit = flashProt(cmdAddr, flash_protection_control_ff);
			end
			`NVMPF_CMD_ERS_FSEC: protHit = flashProt(cmdAddr & `NVMPF_FSEC_MASK, flash_protection_control_ff); // [RULE22]
			`NVMPF_CMD_PGM_EE: protHit = eeprom_protection_control(cmdAddr, eeprom_protection_control_ff);
			`NVMPF_CMD_ERS_ESEC: protHit = eeprom_protection_control(cmdAddr & `NVMPF_ESEC_MASK, eeprom_protection_control_ff); // [RULE22]
			default: protHit = 1'b0;
		endcase
	end
	// a launch with a pending error is ignored until software clears it
	assign setAcc = (launchReq && !errAny && badCmd) ||
		(!command_complete_flag_ff && (wWord || wHi || wLo)); // [RULE10]
	assign setViol = launchReq && !errAny && !badCmd && protHit; // [RULE23]
	assign startRun = launchReq && !errAny && !badCmd && !protHit;

	// =========================================================
	// memory clock and command timing
	nvmpf_state_t state_ff;
	logic [5:0] divCnt_ff;
	logic [15:0] runCnt_ff;
	logic tick, runDone;
	assign tick = divCnt_ff == div_ff;
	assign runDone = state_ff == NVMPF_RUN && tick && runCnt_ff == 16'(CMD_TICKS - 1);
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			div_ff <= `NVMPF_DIV_RESET;
			divSet_ff <= 1'b0;
			divCnt_ff <= 6'h0;
		end
		else
		begin
			if (wDiv)
			begin
				div_ff <= hwdata[`NVMPF_DIV];
				divSet_ff <= 1'b1; // [RULE16]
			end
			divCnt_ff <= tick ? 6'h0 : divCnt_ff + 6'h1;
		end
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			state_ff <= NVMPF_IDLE;
			runCnt_ff <= 16'h0;
		end
		else
		begin
			unique case (state_ff)
				NVMPF_IDLE:
					if (startRun)
					begin
						state_ff <= NVMPF_RUN;
						runCnt_ff <= 16'h0;
					end
				NVMPF_RUN:
					if (runDone)
						state_ff <= NVMPF_IDLE;
					else if (tick)
						runCnt_ff <= runCnt_ff + 16'h1;
			endcase
		end
	end

	// =========================================================
	// status flags: a hardware set wins over a same-cycle clear
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			command_complete_flag_ff <= 1'b1;
			access_error_flag_ff <= 1'b0;
			protection_violation_flag_ff <= 1'b0;
		end
		else
		begin
			if (runDone)
				command_complete_flag_ff <= 1'b1; // [RULE23]
			else if (startRun)
				command_complete_flag_ff <= 1'b0; // [RULE18]
			access_error_flag_ff <= setAcc || (access_error_flag_ff && !(wStat && hwdata[`NVMPF_ACCESS_ERROR_FLAG])); // [RULE17]
			protection_violation_flag_ff <= setViol || (protection_violation_flag_ff && !(wStat && hwdata[`NVMPF_PROTECTION_VIOLATION_FLAG])); // [RULE17]
		end
	end
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			ien_ff <= `NVMPF_IEN_RESET;
			cmdIrq_ff <= 1'b0;
			errIrq_ff <= 1'b0;
		end
		else
		begin
			if (wIen)
				ien_ff <= {hwdata[`NVMPF_CCIE], hwdata[`NVMPF_ERRIE], 6'h0};
			cmdIrq_ff <= command_complete_flag_ff && ien_ff[`NVMPF_CCIE]; // [RULE12]
			errIrq_ff <= errAny && ien_ff[`NVMPF_ERRIE]; // [RULE12]
		end
	end
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_ff;
	assign cmdIrq = cmdIrq_ff;
	assign errIrq = errIrq_ff;

	// =========================================================
	// assertions
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	sequence s_start;
		startRun;
	endsequence
	sequence s_finish;
		runDone;
	endsequence
	property p_launch;
		s_start |=> !command_complete_flag_ff && state_ff == NVMPF_RUN;
	endproperty
	a_launch: assert property (p_launch) else $error("launch did not start"); // [RULE18]
	property p_done;
		s_finish |=> command_complete_flag_ff && state_ff == NVMPF_IDLE;
	endproperty
	a_done: assert property (p_done) else $error("completion flag missing"); // [RULE23]
	property p_viol;
		setViol |=> protection_violation_flag_ff && command_complete_flag_ff && state_ff == NVMPF_IDLE;
	endproperty
	a_viol: assert property (p_viol) else $error("protected target not refused"); // [RULE23]
	property p_clr;
		wStat && hwdata[`NVMPF_ACCESS_ERROR_FLAG] && !setAcc |=> !access_error_flag_ff;
	endproperty
	a_clr: assert property (p_clr) else $error("access error not cleared"); // [RULE17]
	property p_lock;
		!command_complete_flag_ff |=> $stable(obj_ff[0]) && $stable(obj_ff[1]);
	endproperty
	a_lock: assert property (p_lock) else $error("object changed while busy"); // [RULE10]
	property p_full;
		fpScen == `NVMPF_SCEN_FULL |=> fpScen == `NVMPF_SCEN_FULL;
	endproperty
	a_full: assert property (p_full) else $error("left full protection"); // [RULE7]
	property p_fpref;
		wFp && !fpAccept |=> $stable(flash_protection_control_ff);
	endproperty
	a_fpref: assert property (p_fpref) else $error("refused write took effect"); // [RULE24]
	property p_ee;
		!eeprom_protection_control_ff[`NVMPF_OPEN] |=> !eeprom_protection_control_ff[`NVMPF_OPEN] &&
			eeprom_protection_control_ff[`NVMPF_EESZ] >= $past(eeprom_protection_control_ff[`NVMPF_EESZ]);
	endproperty
	a_ee: assert property (p_ee) else $error("eeprom protection reduced"); // [RULE8]
	property p_irq;
		command_complete_flag_ff && ien_ff[`NVMPF_CCIE] |=> cmdIrq;
	endproperty
	a_irq: assert property (p_irq) else $error("complete request missing"); // [RULE12]
endmodule : nvmpf_top

// [sim/nvmpf_top_test.sv]
// self-checking bench for the nvm protection and command front end
`include "nvmpf_params.svh"
module nvmpf_top_test;
	timeunit 1ns;
	timeprecision 1ns;
	import nvmpf_pkg::*;
	logic clk, reset, hsel, hwrite, hreadyout, hresp, cmdIrq, errIrq;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int err_count, n_checks;
	// allowed targets per source scenario, bit t set when t is reachable
	logic [7:0] okRow [8] = '{8'h0f, 8'h0a, 8'h0c, 8'h08, 8'h18, 8'h3c, 8'h5a, 8'hff};
	// protection cases: control value, target address, expected violation
	logic [7:0] pFp [10] = '{8'h8c, 8'h8c, 8'h9c, 8'h9c, 8'h23, 8'h23, 8'ha3, 8'ha3, 8'h24, 8'h80};
	logic [15:0] pAd [10] = '{16'hee00, 16'hf000, 16'hc000, 16'hbe00, 16'h9e00, 16'ha000,
		16'h9e00, 16'ha000, 16'h8000, 16'h8400};
	logic [9:0] pHit = 10'b0101100110;

	// long runs keep the busy window wide enough to observe from the bus
	nvmpf_top #(.CMD_TICKS(20)) uut
	(
		.clk(clk),
		.reset(reset),
		.hsel(hsel),
		.haddr(haddr),
		.htrans(htrans),
		.hwrite(hwrite),
		.hsize(hsize),
		.hwdata(hwdata),
		.hready(hreadyout),
		.hreadyout(hreadyout),
		.hresp(hresp),
		.hrdata(hrdata),
		.cmdIrq(cmdIrq),
		.errIrq(errIrq)
	);

	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ==========================================
	// checking and closing
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			err_count++;
			$display("unexpected at %0t: got %h want %h", $time, seen, exp);
		end
	endtask : check

	task automatic conclude();
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : conclude

	// ==========================================
	// ahb-lite master
	task automatic waitRdy();
		int n;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (hreadyout !== 1'b1 && n < 50);
		if (hreadyout !== 1'b1)
		begin
			err_count++;
			conclude();
		end
	endtask : waitRdy

	// the leading edge leaves one idle cycle, so a read never follows its write directly
	task automatic bus(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= {26'h0, a};
		htrans <= 2'h2;
		hwrite <= w;
		waitRdy();
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		waitRdy();
		rd = hrdata;
		check(32'(hresp), 32'h0);
	endtask : bus

	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(1'b1, a, d);
	endtask : wr

	task automatic rdc(input logic [5:0] a, input logic [31:0] exp);
		bus(1'b0, a, 32'h0);
		check(rd, exp);
	endtask : rdc

	task automatic rst();
		@(posedge clk);
		reset <= 1'b1;
		repeat (20) @(posedge clk);
		reset <= 1'b0;
	endtask : rst

	task automatic waitDone();
		int n;
		n = 0;
		do
		begin
			bus(1'b0, `NVMPF_OFS_STAT, 32'h0);
			n++;
		end
		while (rd[7] !== 1'b1 && n < 100);
		if (rd[7] !== 1'b1)
		begin
			err_count++;
			conclude();
		end
	endtask : waitDone

	// software sequence: clear flags, load code and address, launch, poll
	task automatic cmd(input logic [7:0] c, input logic [15:0] a, input logic [1:0] e);
		wr(`NVMPF_OFS_STAT, 32'h30);
		wr(`NVMPF_OFS_IDX, 32'h0);
		wr(`NVMPF_OFS_HI, {24'h0, c});
		wr(`NVMPF_OFS_LO, 32'h0);
		wr(`NVMPF_OFS_IDX, 32'h1);
		wr(`NVMPF_OFS_WORD, {16'h0, a});
		wr(`NVMPF_OFS_STAT, 32'h80);
		bus(1'b0, `NVMPF_OFS_STAT, 32'h0);
		if (e == 2'b00)
			check(rd, 32'h0);
		waitDone();
		check(rd, {24'h0, 2'b10, e, 4'h0});
	endtask : cmd

	function automatic logic [31:0] enc(input int s);
		return {24'h0, s[2], 1'b0, s[1], 2'b00, s[0], 2'b00};
	endfunction : enc

	// ==========================================
	// main sequence
	initial
	begin
		reset = 1'b1;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'h0;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		err_count = 0;
		n_checks = 0;
		rst();
		rdc(`NVMPF_OFS_STAT, 32'h80);
		rdc(`NVMPF_OFS_FP, 32'ha4);
		rdc(`NVMPF_OFS_EE, 32'h80);
		rdc(`NVMPF_OFS_DIV, 32'h0);
		wr(6'h24, 32'hffff);
		rdc(6'h24, 32'h0);
		$display("test reset done");
		wr(`NVMPF_OFS_IDX, 32'h0);
		wr(`NVMPF_OFS_HI, 32'h06);
		wr(`NVMPF_OFS_LO, 32'h01);
		rdc(`NVMPF_OFS_WORD, 32'h0601);
		rdc(`NVMPF_OFS_HI, 32'h06);
		rdc(`NVMPF_OFS_LO, 32'h01);
		for (int i = 2; i < 6; i++)
		begin
			wr(`NVMPF_OFS_IDX, 32'(i));
			wr(`NVMPF_OFS_WORD, 32'h1111 * i);
		end
		for (int i = 2; i < 6; i++)
		begin
			wr(`NVMPF_OFS_IDX, 32'(i));
			rdc(`NVMPF_OFS_WORD, 32'h1111 * i);
		end
		rdc(`NVMPF_OFS_IDX, 32'h5);
		$display("test object done");
		wr(`NVMPF_OFS_IEN, 32'hc0);
		repeat (2) @(posedge clk);
		check(32'(cmdIrq), 32'h1);
		check(32'(errIrq), 32'h0);
		// divider never written, so the launch is refused
		cmd(8'h0a, 16'h8684, 2'b10);
		check(32'(errIrq), 32'h1);
		wr(`NVMPF_OFS_STAT, 32'h30);
		rdc(`NVMPF_OFS_STAT, 32'h80);
		check(32'(errIrq), 32'h0);
		wr(`NVMPF_OFS_IEN, 32'h40);
		rdc(`NVMPF_OFS_IEN, 32'h40);
		check(32'(cmdIrq), 32'h0);
		$display("test interrupt done");
		wr(`NVMPF_OFS_DIV, 32'h0);
		rdc(`NVMPF_OFS_DIV, 32'h80);
		cmd(8'h06, 16'h8685, 2'b10);
		cmd(8'h06, 16'h8684, 2'b00);
		cmd(8'h0a, 16'h8684, 2'b00);
		cmd(8'h11, 16'h3100, 2'b00);
		cmd(8'h12, 16'h3100, 2'b00);
		wr(`NVMPF_OFS_STAT, 32'h80);
		wr(`NVMPF_OFS_WORD, 32'h5555);
		waitDone();
		check(rd, 32'ha0);
		rdc(`NVMPF_OFS_WORD, 32'h3100);
		$display("test commands done");
		for (int s = 0; s < 8; s++)
			for (int t = 0; t < 8; t++)
			begin
				rst();
				wr(`NVMPF_OFS_FP, enc(s));
				wr(`NVMPF_OFS_FP, enc(t));
				rdc(`NVMPF_OFS_FP, okRow[s][t] ? enc(t) : enc(s));
			end
		rst();
		wr(`NVMPF_OFS_FP, 32'h8c);
		wr(`NVMPF_OFS_FP, 32'h84);
		rdc(`NVMPF_OFS_FP, 32'h8c);
		wr(`NVMPF_OFS_FP, 32'h9c);
		rdc(`NVMPF_OFS_FP, 32'h9c);
		$display("test transitions done");
		for (int i = 0; i < 10; i++)
		begin
			rst();
			wr(`NVMPF_OFS_DIV, 32'h0);
			wr(`NVMPF_OFS_FP, {24'h0, pFp[i]});
			cmd(8'h0a, pAd[i], {1'b0, pHit[i]});
		end
		$display("test flash ranges done");
		rst();
		wr(`NVMPF_OFS_DIV, 32'h0);
		wr(`NVMPF_OFS_EE, 32'h02);
		rdc(`NVMPF_OFS_EE, 32'h02);
		wr(`NVMPF_OFS_EE, 32'h01);
		wr(`NVMPF_OFS_EE, 32'h80);
		rdc(`NVMPF_OFS_EE, 32'h02);
		cmd(8'h11, 16'h3140, 2'b01);
		cmd(8'h11, 16'h3160, 2'b00);
		wr(`NVMPF_OFS_EE, 32'h07);
		cmd(8'h12, 16'h31fe, 2'b01);
		cmd(8'h12, 16'h30fe, 2'b00);
		$display("test eeprom done");
		conclude();
	end
endmodule : nvmpf_top_test
